// ===== nsop_pkg.sv
// shared constants for the oscillator select and fast overrange pin block
package nsop_pkg;

    // datapath widths
    localparam int SAMPLE_W    = 12;            // signed converter sample width
    localparam int PHASE_W     = 32;            // oscillator phase accumulator width
    localparam int HOLD_W      = 8;             // overrange minimum pulse count width
    localparam int NCO_NUM     = 4;             // oscillators per channel
    localparam int SEL_W       = 2;             // select code width per channel
    localparam int CHAN_NUM    = 2;             // channels a and b
    localparam int FLAG_NUM    = 4;             // overrange flags in total
    localparam int SYNC_STAGES = 3;             // select pin synchroniser depth
    localparam int ADDR_W      = 8;             // apb address width
    localparam int DATA_W      = 32;            // apb data width
    localparam int STAT_W      = 6;             // event status bits

    // register byte addresses
    localparam logic [7:0] CTRL_ADDR     = 8'h00;  // pin mode and output format
    localparam logic [7:0] SWSEL_ADDR    = 8'h04;  // register-driven select codes
    localparam logic [7:0] THR1_ADDR     = 8'h08;  // first overrange threshold
    localparam logic [7:0] THR2_ADDR     = 8'h0C;  // second overrange threshold
    localparam logic [7:0] HOLD_ADDR     = 8'h10;  // overrange minimum pulse length
    localparam logic [7:0] FREQA_ADDR    = 8'h14;  // channel a base phase step
    localparam logic [7:0] FREQB_ADDR    = 8'h18;  // channel b base phase step
    localparam logic [7:0] STATUS_ADDR   = 8'h1C;  // sticky events, write one to clear
    localparam logic [7:0] MASK_ADDR     = 8'h20;  // interrupt mask
    localparam logic [7:0] STATE_ADDR    = 8'h24;  // live selection and flags

    // field positions
    localparam int CTRL_PIN_BIT  = 0;           // pin_select_enable
    localparam int CTRL_FMT_LSB  = 1;           // output_format_mode, two bits
    localparam int STAT_SEL_LSB  = 4;           // selection change events
    localparam int STATE_FLG_LSB = 4;           // live overrange flags in state word

    // output format codes
    localparam logic [1:0] FMT_REAL = 2'h0;     // real output, mixer not used

    // reset values
    localparam logic [SAMPLE_W-1:0] THR1_RST = 12'h0_700;
    localparam logic [SAMPLE_W-1:0] THR2_RST = 12'h0_7F0;
    localparam logic [HOLD_W-1:0]   HOLD_RST = 8'h01;
    localparam logic [PHASE_W-1:0]  FREQ_RST = 32'h0100_0000;

endpackage

// ===== nsop_sync.sv
// multi-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module nsop_sync #(
    parameter int WIDTH  = 4,
    parameter int STAGES = 3
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // level in and out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // whole flop chain; stage 0 is read only by stage 1
    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] chain;    // stage 0 catches the pin
    } nsop_sync_t;

    nsop_sync_t s_q;                            // registered state
    nsop_sync_t s_d;                            // next state

    // shift the chain one stage per clock
    always_comb begin
        s_d = s_q;
        s_d.chain[0] = async_in;
        for (int i = 1; i < STAGES; i++) begin
            s_d.chain[i] = s_q.chain[i-1];
        end
    end

    // synchronous active-low reset clears every stage
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.chain[STAGES-1];
endmodule

// ===== nsop_stretch.sv
// overrange flag with programmable minimum high time
`timescale 1ns/1ps
module nsop_stretch #(
    parameter int HOLD_W = 8
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // comparison result and hold length
    input  wire logic              exceed_in,
    input  wire logic [HOLD_W-1:0] min_pulse_in,
    // registered flag
    output logic                   flag_out
);
    // flag and remaining hold cycles
    typedef struct packed {
        logic              flag;                // pin level
        logic [HOLD_W-1:0] cnt;                 // cycles left including current
    } nsop_stretch_t;

    nsop_stretch_t s_q;                         // registered state
    nsop_stretch_t s_d;                         // next state

    // reload on every exceeding sample, then count down
    always_comb begin
        s_d = s_q;
        if (exceed_in) begin
            s_d.flag = 1'b1;
            // a zero length still gives one cycle high
            s_d.cnt  = (min_pulse_in == '0) ? HOLD_W'(1) : min_pulse_in;
        end else if (s_q.cnt > HOLD_W'(1)) begin
            s_d.flag = 1'b1;
            s_d.cnt  = s_q.cnt - HOLD_W'(1);
        end else begin
            s_d.flag = 1'b0;
            s_d.cnt  = '0;
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag_out = s_q.flag;
endmodule

// ===== nsop_top.sv
// oscillator select pins, oscillator banks and fast overrange flag pins
// Behaviour
// - channel a pin code picks one of four oscillators
// - channel b pin code picks its own oscillator
// - unselected oscillators keep advancing phase
// - pins steer selection only when pin mode set and output format not real
// - select pins are asynchronous to the clock
// - first flag high above first threshold
// - second flag high above second threshold
// - flags stay high at least minimum pulse
`timescale 1ns/1ps
module nsop_top
    import nsop_pkg::*;
#(
    parameter int SYNC_DEPTH = nsop_pkg::SYNC_STAGES
) (
    // clock and reset
    input  wire logic                          CLK_IN,
    input  wire logic                          RST_N_IN,
    // apb slave
    input  wire logic                          PSEL_IN,
    input  wire logic                          PENABLE_IN,
    input  wire logic                          PWRITE_IN,
    input  wire logic [nsop_pkg::ADDR_W-1:0]   PADDR_IN,
    input  wire logic [nsop_pkg::DATA_W-1:0]   PWDATA_IN,
    output logic      [nsop_pkg::DATA_W-1:0]   PRDATA_OUT,
    output logic                               PREADY_OUT,
    output logic                               PSLVERR_OUT,
    // oscillator select pins
    input  wire logic                          OSC_SEL_A_LSB_IN,
    input  wire logic                          OSC_SEL_A_MSB_IN,
    input  wire logic                          OSC_SEL_B_LSB_IN,
    input  wire logic                          OSC_SEL_B_MSB_IN,
    // converter samples, signed
    input  wire logic [nsop_pkg::SAMPLE_W-1:0] SAMPLE_A_IN,
    input  wire logic [nsop_pkg::SAMPLE_W-1:0] SAMPLE_B_IN,
    // overrange flag pins
    output logic                               OVR_FLAG_A_FIRST_OUT,
    output logic                               OVR_FLAG_A_SECOND_OUT,
    output logic                               OVR_FLAG_B_FIRST_OUT,
    output logic                               OVR_FLAG_B_SECOND_OUT,
    // mixer phase and active selection
    output logic      [nsop_pkg::PHASE_W-1:0]  PHASE_A_OUT,
    output logic      [nsop_pkg::PHASE_W-1:0]  PHASE_B_OUT,
    output logic      [nsop_pkg::SEL_W-1:0]    OSC_SEL_A_OUT,
    output logic      [nsop_pkg::SEL_W-1:0]    OSC_SEL_B_OUT,
    // interrupt
    output logic                               IRQ_OUT
);
    import nsop_pkg::*;

    // all registered state of the block
    typedef struct packed {
        logic [DATA_W-1:0]                        prdata;    // read data
        logic                                     pready;    // access phase answer
        logic                                     pslverr;   // unmapped address
        logic                                     irq;       // interrupt pin
        logic                                     pin_mode;  // pin_select_enable
        logic [1:0]                               fmt;       // output_format_mode
        logic [CHAN_NUM-1:0][SEL_W-1:0]           sw_sel;    // register select codes
        logic [SAMPLE_W-1:0]                      thr1;      // first threshold
        logic [SAMPLE_W-1:0]                      thr2;      // second threshold
        logic [HOLD_W-1:0]                        hold;      // overrange_min_pulse
        logic [CHAN_NUM-1:0][PHASE_W-1:0]         freq;      // base phase step
        logic [STAT_W-1:0]                        status;    // sticky events
        logic [STAT_W-1:0]                        mask;      // interrupt enables
        logic [CHAN_NUM-1:0][SEL_W-1:0]           sel;       // active oscillator
        logic [CHAN_NUM-1:0][NCO_NUM-1:0][PHASE_W-1:0] phase; // accumulators
        logic [CHAN_NUM-1:0][PHASE_W-1:0]         phase_out; // mixer phase
        logic [FLAG_NUM-1:0]                      flag_prev; // flags a cycle ago
    } nsop_state_t;

    nsop_state_t s_q;                           // registered state
    nsop_state_t s_d;                           // next state

    logic [FLAG_NUM-1:0]              pins_raw;  // raw select pins
    logic [FLAG_NUM-1:0]              pins_sync; // synchronised select pins
    logic [CHAN_NUM-1:0][SEL_W-1:0]   pin_code;  // per channel pin code
    logic [CHAN_NUM-1:0][SAMPLE_W-1:0] mag;      // sample magnitudes
    logic [FLAG_NUM-1:0]              exceed;    // threshold comparisons
    logic [FLAG_NUM-1:0]              flags;     // stretched flags
    logic                             apb_setup; // setup phase seen
    logic                             apb_wr;    // write takes effect
    logic [DATA_W-1:0]                wdata;     // write data alias

    // pins arrive with no timing relation to the clock, so they go
    // through a flop chain before any logic sees them
    assign pins_raw = {OSC_SEL_B_MSB_IN, OSC_SEL_B_LSB_IN,
                       OSC_SEL_A_MSB_IN, OSC_SEL_A_LSB_IN};

    nsop_sync #(
        .WIDTH  (FLAG_NUM),
        .STAGES (SYNC_DEPTH)
    ) u_sync (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    // channel a code from its lsb and msb pins, channel b likewise
    assign pin_code[0] = pins_sync[1:0];
    assign pin_code[1] = pins_sync[3:2];

    // magnitude of a signed sample; the most negative code maps to
    // 12'h800, one above the largest positive magnitude, which still compares correctly
    function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
        magnitude = s[SAMPLE_W-1] ? SAMPLE_W'(~s + SAMPLE_W'(1)) : s;
    endfunction

    assign mag[0] = magnitude(SAMPLE_A_IN);
    assign mag[1] = magnitude(SAMPLE_B_IN);

    // one comparator and one stretcher per flag; flag index is
    // channel times two plus threshold number
    for (genvar f = 0; f < FLAG_NUM; f++) begin : g_flag
        if (f % 2 == 0) begin : g_first
            assign exceed[f] = mag[f/2] > s_q.thr1;
        end else begin : g_second
            assign exceed[f] = mag[f/2] > s_q.thr2;
        end
        nsop_stretch #(
            .HOLD_W (HOLD_W)
        ) u_stretch (
            .clk_in       (CLK_IN),
            .rst_n_in     (RST_N_IN),
            .exceed_in    (exceed[f]),
            .min_pulse_in (s_q.hold),
            .flag_out     (flags[f])
        );
    end

    // apb phases; pready is raised for the access cycle so every
    // transfer completes with no wait state
    assign apb_setup = PSEL_IN && !PENABLE_IN;
    assign apb_wr    = PSEL_IN && PENABLE_IN && s_q.pready && PWRITE_IN && !s_q.pslverr;
    assign wdata     = PWDATA_IN;

    // next-state logic for bus, selection, oscillators and events
    always_comb begin
        s_d = s_q;

        // answer prepared in the setup cycle, shown in the access cycle
        s_d.pready  = apb_setup;
        s_d.pslverr = 1'b0;
        if (apb_setup) begin
            s_d.prdata = '0;
            case (PADDR_IN)
                CTRL_ADDR: begin
                    s_d.prdata[CTRL_PIN_BIT] = s_q.pin_mode;
                    s_d.prdata[CTRL_FMT_LSB +: 2] = s_q.fmt;
                end
                SWSEL_ADDR: begin
                    s_d.prdata[2*SEL_W-1:0] = s_q.sw_sel;
                end
                THR1_ADDR: begin
                    s_d.prdata[SAMPLE_W-1:0] = s_q.thr1;
                end
                THR2_ADDR: begin
                    s_d.prdata[SAMPLE_W-1:0] = s_q.thr2;
                end
                HOLD_ADDR: begin
                    s_d.prdata[HOLD_W-1:0] = s_q.hold;
                end
                FREQA_ADDR: begin
                    s_d.prdata = s_q.freq[0];
                end
                FREQB_ADDR: begin
                    s_d.prdata = s_q.freq[1];
                end
                STATUS_ADDR: begin
                    s_d.prdata[STAT_W-1:0] = s_q.status;
                end
                MASK_ADDR: begin
                    s_d.prdata[STAT_W-1:0] = s_q.mask;
                end
                STATE_ADDR: begin
                    // live selection and flag levels
                    s_d.prdata[2*SEL_W-1:0] = s_q.sel;
                    s_d.prdata[STATE_FLG_LSB +: FLAG_NUM] = flags;
                end
                default: begin
                    // unmapped: zero data and an error answer
                    s_d.pslverr = 1'b1;
                end
            endcase
        end

        // register writes at the access edge with pready high
        if (apb_wr) begin
            case (PADDR_IN)
                CTRL_ADDR: begin
                    s_d.pin_mode = wdata[CTRL_PIN_BIT];
                    s_d.fmt      = wdata[CTRL_FMT_LSB +: 2];
                end
                SWSEL_ADDR: begin
                    s_d.sw_sel = wdata[2*SEL_W-1:0];
                end
                THR1_ADDR: begin
                    s_d.thr1 = wdata[SAMPLE_W-1:0];
                end
                THR2_ADDR: begin
                    s_d.thr2 = wdata[SAMPLE_W-1:0];
                end
                HOLD_ADDR: begin
                    s_d.hold = wdata[HOLD_W-1:0];
                end
                FREQA_ADDR: begin
                    s_d.freq[0] = wdata;
                end
                FREQB_ADDR: begin
                    s_d.freq[1] = wdata;
                end
                STATUS_ADDR: begin
                    // write one to clear; new events below win
                    s_d.status = s_q.status & ~wdata[STAT_W-1:0];
                end
                MASK_ADDR: begin
                    s_d.mask = wdata[STAT_W-1:0];
                end
                default: begin
                    // read-only or unmapped, nothing stored
                end
            endcase
        end

        // active oscillator per channel
        for (int c = 0; c < CHAN_NUM; c++) begin
            if (s_q.fmt == FMT_REAL) begin
                // real output bypasses the mixer, hold oscillator 0
                s_d.sel[c] = '0;
            end else if (s_q.pin_mode) begin
                s_d.sel[c] = pin_code[c];
            end else begin
                // pins ignored; register code steers instead
                s_d.sel[c] = s_q.sw_sel[c];
            end
        end

        // every accumulator advances each clock whether or not it is
        // selected, so a switch picks up a coherent running phase;
        // oscillator k steps at (k+1) times the channel base step
        for (int c = 0; c < CHAN_NUM; c++) begin
            for (int k = 0; k < NCO_NUM; k++) begin
                s_d.phase[c][k] = s_q.phase[c][k]
                                  + PHASE_W'(s_q.freq[c] * PHASE_W'(k + 1));
            end
            // mixer sees the selected accumulator
            s_d.phase_out[c] = s_q.phase[c][s_q.sel[c]];
        end

        // sticky events: flag rises and selection changes
        s_d.flag_prev = flags;
        for (int f = 0; f < FLAG_NUM; f++) begin
            if (flags[f] && !s_q.flag_prev[f]) begin
                s_d.status[f] = 1'b1;
            end
        end
        for (int c = 0; c < CHAN_NUM; c++) begin
            if (s_d.sel[c] != s_q.sel[c]) begin
                s_d.status[STAT_SEL_LSB + c] = 1'b1;
            end
        end

        // level interrupt from unmasked sticky bits
        s_d.irq = |(s_d.status & s_q.mask);
    end

    // state register with synchronous active-low reset
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            s_q          <= '0;
            s_q.thr1     <= THR1_RST;
            s_q.thr2     <= THR2_RST;
            s_q.hold     <= HOLD_RST;
            s_q.freq[0]  <= FREQ_RST;
            s_q.freq[1]  <= FREQ_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // every output taken straight from a flop
    assign PRDATA_OUT            = s_q.prdata;
    assign PREADY_OUT            = s_q.pready;
    assign PSLVERR_OUT           = s_q.pslverr;
    assign OVR_FLAG_A_FIRST_OUT  = flags[0];
    assign OVR_FLAG_A_SECOND_OUT = flags[1];
    assign OVR_FLAG_B_FIRST_OUT  = flags[2];
    assign OVR_FLAG_B_SECOND_OUT = flags[3];
    assign PHASE_A_OUT           = s_q.phase_out[0];
    assign PHASE_B_OUT           = s_q.phase_out[1];
    assign OSC_SEL_A_OUT         = s_q.sel[0];
    assign OSC_SEL_B_OUT         = s_q.sel[1];
    assign IRQ_OUT               = s_q.irq;
endmodule

// ===== nsop_monitor.sv
// assertion checker for the select and overrange pin block
`timescale 1ns/1ps
module nsop_monitor
    import nsop_pkg::*;
(
    // clock, reset and apb write path
    input  wire logic                CLK_IN,
    input  wire logic                RST_N_IN,
    input  wire logic                PSEL_IN,
    input  wire logic                PENABLE_IN,
    input  wire logic                PWRITE_IN,
    input  wire logic [ADDR_W-1:0]   PADDR_IN,
    input  wire logic [DATA_W-1:0]   PWDATA_IN,
    input  wire logic                PREADY_OUT,
    // select pins and samples
    input  wire logic                OSC_SEL_A_LSB_IN,
    input  wire logic                OSC_SEL_A_MSB_IN,
    input  wire logic                OSC_SEL_B_LSB_IN,
    input  wire logic                OSC_SEL_B_MSB_IN,
    input  wire logic [SAMPLE_W-1:0] SAMPLE_A_IN,
    input  wire logic [SAMPLE_W-1:0] SAMPLE_B_IN,
    // flags and selection
    input  wire logic                OVR_FLAG_A_FIRST_OUT,
    input  wire logic                OVR_FLAG_A_SECOND_OUT,
    input  wire logic                OVR_FLAG_B_FIRST_OUT,
    input  wire logic                OVR_FLAG_B_SECOND_OUT,
    input  wire logic [SEL_W-1:0]    OSC_SEL_A_OUT,
    input  wire logic [SEL_W-1:0]    OSC_SEL_B_OUT
);
    import nsop_pkg::*;
    logic [11:0] thr1_q;   // shadow first threshold
    logic [11:0] thr2_q;   // shadow second threshold
    logic [7:0]  hold_q;   // shadow minimum pulse
    logic [2:0]  ctrl_q;   // shadow pin mode and format
    logic        wr;       // apb write completes this edge
    logic        pin_on;   // pins steer the selection
    assign wr     = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
    assign pin_on = ctrl_q[0] && (ctrl_q[2:1] != 2'h0);
    // shadows follow completed writes
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            thr1_q <= THR1_RST;
            thr2_q <= THR2_RST;
            hold_q <= HOLD_RST;
            ctrl_q <= 3'h0;
        end else if (wr) begin
            case (PADDR_IN)
                THR1_ADDR: thr1_q <= PWDATA_IN[11:0];
                THR2_ADDR: thr2_q <= PWDATA_IN[11:0];
                HOLD_ADDR: hold_q <= PWDATA_IN[7:0];
                CTRL_ADDR: ctrl_q <= PWDATA_IN[2:0];
                default: ;
            endcase
        end
    end
    // one bit wider: most negative sample cannot wrap
    function automatic logic [12:0] mag(input logic [11:0] s);
        return s[11] ? 13'h1_000 - {1'b0, s} : {1'b0, s};
    endfunction
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // pin code held past the synchroniser
    sequence settled_a;
        (pin_on && $stable({OSC_SEL_A_MSB_IN, OSC_SEL_A_LSB_IN}))[*5];
    endsequence
    sequence settled_b;
        (pin_on && $stable({OSC_SEL_B_MSB_IN, OSC_SEL_B_LSB_IN}))[*5];
    endsequence
    chk_pin_sel_a: assert property (settled_a |->
        OSC_SEL_A_OUT == {OSC_SEL_A_MSB_IN, OSC_SEL_A_LSB_IN}) else $error("select a wrong");
    chk_pin_sel_b: assert property (settled_b |->
        OSC_SEL_B_OUT == {OSC_SEL_B_MSB_IN, OSC_SEL_B_LSB_IN}) else $error("select b wrong");
    chk_pins_ignored: assert property ((!pin_on && !wr)[*5] |=>
        $stable(OSC_SEL_A_OUT) && $stable(OSC_SEL_B_OUT)) else $error("pins moved selection");
    chk_ovr_a_first: assert property (mag(SAMPLE_A_IN) > thr1_q |=>
        OVR_FLAG_A_FIRST_OUT) else $error("a1 missing");
    chk_ovr_b_first: assert property (mag(SAMPLE_B_IN) > thr1_q |=>
        OVR_FLAG_B_FIRST_OUT) else $error("b1 missing");
    chk_ovr_a_second: assert property (mag(SAMPLE_A_IN) > thr2_q |=>
        OVR_FLAG_A_SECOND_OUT) else $error("a2 missing");
    chk_ovr_b_second: assert property (mag(SAMPLE_B_IN) > thr2_q |=>
        OVR_FLAG_B_SECOND_OUT) else $error("b2 missing");
    chk_ovr_min_pulse: assert property ($rose(OVR_FLAG_A_FIRST_OUT) && hold_q == 8'd4 |->
        OVR_FLAG_A_FIRST_OUT[*4]) else $error("pulse short");
    chk_apb_ready: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
        else $error("ready timing");
endmodule
bind nsop_top nsop_monitor u_mon (.*);

// ===== nsop_pin_host.sv
// far-side logic driving the select pins
`timescale 1ns/1ps
module nsop_pin_host (
    // codes requested by the bench, {msb,lsb}
    input  wire logic [1:0] code_a_in,
    input  wire logic [1:0] code_b_in,
    // select pins
    output wire logic       sel_a_lsb_out,
    output wire logic       sel_a_msb_out,
    output wire logic       sel_b_lsb_out,
    output wire logic       sel_b_msb_out
);
    // skewed pin moves off the clock edge
    assign #1.3 sel_a_lsb_out = code_a_in[0];
    assign #1.7 sel_a_msb_out = code_a_in[1];
    assign #1.1 sel_b_lsb_out = code_b_in[0];
    assign #1.9 sel_b_msb_out = code_b_in[1];
endmodule

// ===== nsop_top_test.sv
// self-checking bench for the select and overrange pin block
`timescale 1ns/1ps
module nsop_top_test;
    import nsop_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, ph_a, ph_b, rd, p1;
    logic [11:0] smp_a, smp_b;
    logic [3:0]  flg;                     // a1 a2 b1 b2
    logic [1:0]  code_a, code_b, sel_a, sel_b;
    logic        pa0, pa1, pb0, pb1;      // far-side pins
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;
    int          cnt [4];                 // high cycles seen per flag
    int          c1;
    nsop_pin_host host (.code_a_in(code_a), .code_b_in(code_b), .sel_a_lsb_out(pa0),
        .sel_a_msb_out(pa1), .sel_b_lsb_out(pb0), .sel_b_msb_out(pb1));
    nsop_top uut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .OSC_SEL_A_LSB_IN(pa0),
        .OSC_SEL_A_MSB_IN(pa1), .OSC_SEL_B_LSB_IN(pb0), .OSC_SEL_B_MSB_IN(pb1),
        .SAMPLE_A_IN(smp_a), .SAMPLE_B_IN(smp_b), .OVR_FLAG_A_FIRST_OUT(flg[0]),
        .OVR_FLAG_A_SECOND_OUT(flg[1]), .OVR_FLAG_B_FIRST_OUT(flg[2]),
        .OVR_FLAG_B_SECOND_OUT(flg[3]), .PHASE_A_OUT(ph_a), .PHASE_B_OUT(ph_b),
        .OSC_SEL_A_OUT(sel_a), .OSC_SEL_B_OUT(sel_b), .IRQ_OUT(irq));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one apb transfer, sampled where ready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // one-cycle sample, then count flag high cycles
    task automatic pulse(input logic [11:0] a, input logic [11:0] b);
        @(posedge clk);
        smp_a <= a;
        smp_b <= b;
        @(posedge clk);
        smp_a <= 12'h0_000;
        smp_b <= 12'h0_000;
        cnt = '{0, 0, 0, 0};
        repeat (12) begin
            @(posedge clk);
            for (int i = 0; i < 4; i++) cnt[i] += int'(flg[i]);
        end
    endtask
    task automatic t_regs();
        logic [7:0]  ad [6] = '{THR1_ADDR, THR2_ADDR, HOLD_ADDR, FREQA_ADDR, CTRL_ADDR, 8'h40};
        logic [31:0] ex [6] = '{32'h0000_0700, 32'h0000_07F0, 32'h0000_0001,
                                32'h0100_0000, 32'h0000_0000, 32'h0000_0000};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ad[i], 32'h0000_0000);
            check("read data", ex[i], rd);
            check("slave error", 32'(i == 5), 32'(err));
        end
    endtask
    task automatic t_sel_pins();
        apb(1'b1, CTRL_ADDR, 32'h0000_0003);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            code_a <= 2'(k);
            code_b <= 2'(3 - k);
            repeat (2) @(posedge clk);
            check("sel a early", 32'(k == 0 ? 0 : k - 1), 32'(sel_a));
            repeat (6) @(posedge clk);
            check("select a", 32'(k), 32'(sel_a));
            check("select b", 32'(3 - k), 32'(sel_b));
        end
    endtask
    task automatic t_sel_ignore();
        apb(1'b1, SWSEL_ADDR, 32'h0000_0006);
        apb(1'b1, CTRL_ADDR, 32'h0000_0002);
        code_a <= 2'h1;
        code_b <= 2'h3;
        repeat (8) @(posedge clk);
        check("sel a sw", 32'h0000_0002, 32'(sel_a));
        check("sel b sw", 32'h0000_0001, 32'(sel_b));
    endtask
    task automatic t_phase();
        apb(1'b1, CTRL_ADDR, 32'h0000_0003);
        repeat (8) @(posedge clk);
        p1 = ph_a;
        c1 = cycles;
        code_a <= 2'h3;
        repeat (10) @(posedge clk);
        p1 = p1 + 32'(cycles - c1) * 32'd2 * FREQ_RST;
        c1 = cycles;
        rd = ph_a;
        @(posedge clk);
        check("osc3 step", 32'd4 * FREQ_RST, ph_a - rd);
        code_a <= 2'h1;
        repeat (12) @(posedge clk);
        check("phase coherent", p1 + 32'(cycles - c1) * 32'd2 * FREQ_RST, ph_a);
    endtask
    task automatic t_ovr();
        apb(1'b1, HOLD_ADDR, 32'h0000_0004);
        apb(1'b1, MASK_ADDR, 32'h0000_0001);
        apb(1'b1, STATUS_ADDR, 32'h0000_003F);
        pulse(12'h7_00, 12'h0_000);
        check("at thr", 32'h0, 32'(cnt[0] + cnt[1]));
        pulse(12'h7_01, 12'h0_000);
        check("a1 cycles", 32'd4, 32'(cnt[0]));
        check("a2 cycles", 32'd0, 32'(cnt[1]));
        check("irq raised", 32'h1, 32'(irq));
        apb(1'b1, STATUS_ADDR, 32'h0000_0001);
        @(posedge clk);
        check("irq cleared", 32'h0, 32'(irq));
        pulse(12'h0_000, 12'h8_0F);
        check("b1 cycles", 32'd4, 32'(cnt[2]));
        check("b2 cycles", 32'd4, 32'(cnt[3]));
        check("irq masked", 32'h0, 32'(irq));
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        check("status", 32'h0000_000C, rd);
    endtask
    initial begin
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        smp_a   = 12'h0_000;
        smp_b   = 12'h0_000;
        code_a  = 2'h0;
        code_b  = 2'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_sel_pins();
        t_sel_ignore();
        t_phase();
        t_ovr();
        complete_run();
    end
endmodule
